// File: cpi_cfg.svh
// constants of the control panel interface: codes, fields, levels and timing
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH

// ----------------------------------------------------------------
// serial link timing
// ----------------------------------------------------------------
`define CPI_CLK_HZ 50000000
`define CPI_BAUD 4800
`define CPI_BIT_CYCLES ((`CPI_CLK_HZ + `CPI_BAUD / 2) / `CPI_BAUD)
`define CPI_TMR_W 14
`define CPI_DATA_BITS 4'h8
`define CPI_FRAME_BITS 4'hA

// ----------------------------------------------------------------
// command bytes, panel to host
// ----------------------------------------------------------------
`define CPI_CMD_HI 4'h4
`define CPI_CMD_MASTER_CLEAR 8'h40
`define CPI_CMD_LOAD_REGISTER 8'h41
`define CPI_CMD_READ_REGISTER 8'h42
`define CPI_CMD_READ_STATUS 8'h43
`define CPI_CMD_LOAD_LOADER 8'h44
`define CPI_CMD_LOAD_MEMORY 8'h45
`define CPI_CMD_INTERRUPT 8'h46
`define CPI_CMD_READ_MEMORY 8'h47
`define CPI_CMD_LOAD_ADDRESS 8'h48
`define CPI_CMD_READ_ADDRESS 8'h4A
`define CPI_CMD_RUN 8'h4B
`define CPI_CMD_LOAD_MEMORY_SECOND 8'h55
`define CPI_CMD_READ_MEMORY_SECOND 8'h57

// ----------------------------------------------------------------
// digit bytes and replies
// ----------------------------------------------------------------
`define CPI_DIG_REG_HI 4'h3
`define CPI_DIG_MEM_HI 4'hB
`define CPI_DIGITS_REG_LOAD 3'h5
`define CPI_DIGITS_REG_ADDR 3'h1
`define CPI_DIGITS_WORD 3'h4
`define CPI_DIGITS_MEM_ADDR 3'h5
`define CPI_REPLY_NOT_RUNNING 8'h40
`define CPI_REPLY_RUNNING 8'h41

// ----------------------------------------------------------------
// status word, levels, addresses
// ----------------------------------------------------------------
`define CPI_PSW_PL_LSB 0
`define CPI_PSW_PL_W 6
`define CPI_PSW_CR_LSB 6
`define CPI_PSW_ENB_BIT 8
`define CPI_PSW_USER_BIT 15
`define CPI_LEVEL_POWER 6'h00
`define CPI_LEVEL_RESTART 6'h00
`define CPI_LEVEL_PANEL 6'h03
`define CPI_LEVEL_PLANNED_OFF 6'h04
`define CPI_LEVEL_LOADER 6'h3F
`define CPI_LOADER_FIRST 16'h0000
`define CPI_LOADER_LAST 16'h01FE
`define CPI_LOADER_PARAM_FIRST 16'h01E0
`define CPI_LOADER_PARAM_LAST 16'h01EF
`define CPI_RESTART_ADDR 16'h0000
`define CPI_EXT_PANEL_ADDR 8'hF6

// ----------------------------------------------------------------
// status buffer source bits
// ----------------------------------------------------------------
`define CPI_SRC_SERIAL 0
`define CPI_SRC_RUN 1
`define CPI_SRC_OFF 2
`define CPI_SRC_POWER 3

`endif

// File: cpi_pkg.sv
// types of the control panel interface
package cpi_pkg;

	// receiver states
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} cpi_rx_e;

	// transmitter states
	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SHIFT = 2'h2
	} cpi_tx_e;

	// command interpreter states
	typedef enum logic [3:0] {
		CT_CMD = 4'h1,
		CT_COLLECT = 4'h2,
		CT_WAIT = 4'h4,
		CT_SEND = 4'h8
	} cpi_ctl_e;

endpackage

// File: cpi_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module cpi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second, nothing else looks at it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else if (i_ce) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// File: cpi_panel_if.sv
// control panel interface: serial panel interpreter, operator panel lines, power-up and shutdown
//
// Operation
// - serial link at 4.8 kbaud, one line each way
// - start bit raises a firmware interrupt
// - interrupt source kept in a status buffer
// - timer samples each incoming bit, then decode
// - replies sent on host-to-panel line; panel reset
// - lock ignores all commands except interrupt
// - decode 40-4F, 55 and 57 command bytes
// - register address and data digits as 3x
// - memory address digits as five Bx bytes
// - reply 40 idle, 41 running
// - read status returns the status word
// - load loader sets level 63, flags cleared
// - interrupt command raises level 3
// - operator panel external register at F6
// - run request interrupts and starts loader
// - power-good rise gives level 0, tests restart
// - restart: system clear, level 00, branch 0, run
// - planned off while running raises level 4
// - planned off while idle drives software off
// - tick enable gates the clock tick
// - power-up without lock or restart request goes idle, else reload/restart
// - level 3 vectors through address 0006
`timescale 1ns/1ns
`include "cpi_cfg.svh"
module cpi_panel_if
	import cpi_pkg::*;
#(
	parameter int BIT_CYCLES = `CPI_BIT_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_serial_panel_to_host,
	output logic o_serial_host_to_panel,
	output logic o_handheld_panel_reset,
	input wire logic i_lock,
	input wire logic i_rtc_tick,
	input wire logic i_rtc_tick_enable,
	output logic o_rtc_tick,
	input wire logic i_run_request_n,
	input wire logic i_restart_request,
	input wire logic i_planned_off_request_n,
	input wire logic i_power_good_monitor,
	input wire logic i_memory_retained,
	output logic o_system_clear_n,
	output logic o_software_off_n,
	input wire logic [5:0] i_operator_panel_data,
	output logic [7:0] o_operator_panel_data,
	input wire logic i_ext_rd,
	input wire logic i_ext_wr,
	input wire logic [7:0] i_ext_addr,
	input wire logic [7:0] i_ext_wdata,
	output logic [7:0] o_ext_rdata,
	output logic o_fw_interrupt,
	output logic [3:0] o_fw_source,
	input wire logic [3:0] i_fw_source_clr,
	output logic o_int_req,
	output logic [5:0] o_int_level,
	output logic [15:0] o_int_vector,
	output logic o_cmd_valid,
	output logic [7:0] o_cmd_code,
	output logic [19:0] o_cmd_operand,
	input wire logic [15:0] i_psw,
	input wire logic i_reply_valid,
	input wire logic [15:0] i_reply_data,
	output logic o_psw_load,
	output logic [15:0] o_psw_value,
	output logic o_loader_load,
	output logic o_auto_restart,
	output logic o_branch,
	output logic [15:0] o_branch_addr,
	output logic o_run_state
);
	localparam logic [`CPI_TMR_W-1:0] BIT_T = `CPI_TMR_W'(BIT_CYCLES - 1);
	localparam logic [`CPI_TMR_W-1:0] HALF_T = `CPI_TMR_W'(BIT_CYCLES / 2 - 1);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [14:0] pins_s;
	logic ser_s, lock_s, tick_s, tick_en_s, run_n_s, restart_s, pon_n_s, pg_s, retained_s;
	logic [5:0] op_s;

	// idle-high and active-low lines start high so reset makes no false edge
	cpi_sync #(.W(15), .INIT(15'h0051)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_async({i_operator_panel_data, i_memory_retained, i_power_good_monitor, i_planned_off_request_n,
			i_restart_request, i_run_request_n, i_rtc_tick_enable, i_rtc_tick, i_lock, i_serial_panel_to_host}),
		.o_sync(pins_s)
	);
	assign {op_s, retained_s, pg_s, pon_n_s, restart_s, run_n_s, tick_en_s, tick_s, lock_s, ser_s} = pins_s;

	// ----------------------------------------------------------------
	// serial receiver
	// ----------------------------------------------------------------
	cpi_rx_e rx_q, rx_d;
	logic [`CPI_TMR_W-1:0] rx_tmr_q, rx_tmr_d;
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
	logic rx_valid_q, rx_valid_d, rx_start_q, rx_start_d;

	// half a bit after the falling edge, then one bit time per sample
	always_comb begin
		rx_d = rx_q;
		rx_tmr_d = rx_tmr_q;
		rx_cnt_d = rx_cnt_q;
		rx_sh_d = rx_sh_q;
		rx_byte_d = rx_byte_q;
		rx_valid_d = 1'b0;
		rx_start_d = 1'b0;
		unique case (rx_q)
			RX_IDLE: begin
				if (!ser_s) begin
					rx_start_d = 1'b1;
					rx_tmr_d = HALF_T;
					rx_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_tmr_q != '0) begin
					rx_tmr_d = rx_tmr_q - 1'b1;
				end else if (ser_s) begin
					rx_d = RX_IDLE; // a glitch, not a start bit
				end else begin
					rx_tmr_d = BIT_T;
					rx_cnt_d = `CPI_DATA_BITS;
					rx_d = RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_tmr_q != '0) begin
					rx_tmr_d = rx_tmr_q - 1'b1;
				end else begin
					rx_sh_d = {ser_s, rx_sh_q[7:1]};
					rx_tmr_d = BIT_T;
					rx_cnt_d = rx_cnt_q - 1'b1;
					if (rx_cnt_q == 4'h1) begin
						rx_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_tmr_q != '0) begin
					rx_tmr_d = rx_tmr_q - 1'b1;
				end else begin
					rx_valid_d = ser_s; // framing error drops the byte
					rx_byte_d = rx_sh_q;
					rx_d = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_q <= RX_IDLE;
			rx_tmr_q <= '0;
			rx_cnt_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_valid_q <= 1'b0;
			rx_start_q <= 1'b0;
		end else if (i_ce) begin
			rx_q <= rx_d;
			rx_tmr_q <= rx_tmr_d;
			rx_cnt_q <= rx_cnt_d;
			rx_sh_q <= rx_sh_d;
			rx_byte_q <= rx_byte_d;
			rx_valid_q <= rx_valid_d;
			rx_start_q <= rx_start_d;
		end
	end

	// ----------------------------------------------------------------
	// serial transmitter
	// ----------------------------------------------------------------
	cpi_tx_e tx_q, tx_d;
	logic [`CPI_TMR_W-1:0] tx_tmr_q, tx_tmr_d;
	logic [3:0] tx_cnt_q, tx_cnt_d;
	logic [9:0] tx_sh_q, tx_sh_d;
	logic tx_out_q, tx_out_d;
	logic tx_go_q;
	logic [7:0] tx_byte_q;

	// start, data lsb first, stop; the line rests high
	always_comb begin
		tx_d = tx_q;
		tx_tmr_d = tx_tmr_q;
		tx_cnt_d = tx_cnt_q;
		tx_sh_d = tx_sh_q;
		tx_out_d = tx_out_q;
		unique case (tx_q)
			TX_IDLE: begin
				tx_out_d = 1'b1;
				if (tx_go_q) begin
					tx_sh_d = {1'b1, tx_byte_q, 1'b0};
					tx_cnt_d = `CPI_FRAME_BITS;
					tx_tmr_d = '0;
					tx_d = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tx_tmr_q != '0) begin
					tx_tmr_d = tx_tmr_q - 1'b1;
				end else if (tx_cnt_q == 4'h0) begin
					tx_d = TX_IDLE;
				end else begin
					tx_out_d = tx_sh_q[0];
					tx_sh_d = {1'b1, tx_sh_q[9:1]};
					tx_cnt_d = tx_cnt_q - 1'b1;
					tx_tmr_d = BIT_T;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tx_q <= TX_IDLE;
			tx_tmr_q <= '0;
			tx_cnt_q <= 4'h0;
			tx_sh_q <= 10'h3FF;
			tx_out_q <= 1'b1;
		end else if (i_ce) begin
			tx_q <= tx_d;
			tx_tmr_q <= tx_tmr_d;
			tx_cnt_q <= tx_cnt_d;
			tx_sh_q <= tx_sh_d;
			tx_out_q <= tx_out_d;
		end
	end

	// ----------------------------------------------------------------
	// command interpreter and panel events
	// ----------------------------------------------------------------
	cpi_ctl_e ctl_q, ctl_d;
	logic [7:0] cmd_q, cmd_d, tx_byte_d, cmd_code_q, cmd_code_d;
	logic [19:0] acc_q, acc_d, operand_q, operand_d;
	logic [2:0] dig_q, dig_d, send_cnt_q, send_cnt_d;
	logic [3:0] dig_hi_q, dig_hi_d, src_q, src_d, src_set;
	logic [15:0] buf_q, buf_d, psw_val_q, psw_val_d, vec_q, vec_d;
	logic [5:0] lvl_q, lvl_d;
	logic send_run_q, send_run_d, tx_go_d, run_q, run_d, psw_ld_q, psw_ld_d, loader_q, loader_d;
	logic auto_q, auto_d, branch_q, branch_d, clear_n_q, clear_n_d, swoff_n_q, swoff_n_d;
	logic int_q, int_d, cmd_v_q, cmd_v_d, fw_int_q, fw_int_d, hh_rst_q, hh_rst_d;
	logic pg_prev_q, run_prev_q, pon_prev_q, pg_rise, run_fall, pon_fall, known, allowed;

	assign pg_rise = pg_s && !pg_prev_q;
	assign run_fall = !run_n_s && run_prev_q;
	assign pon_fall = !pon_n_s && pon_prev_q;
	assign known = (rx_byte_q[7:4] == `CPI_CMD_HI) || (rx_byte_q == `CPI_CMD_LOAD_MEMORY_SECOND)
		|| (rx_byte_q == `CPI_CMD_READ_MEMORY_SECOND);
	assign allowed = !lock_s || (rx_byte_q == `CPI_CMD_INTERRUPT);

	always_comb begin
		ctl_d = ctl_q;
		cmd_d = cmd_q;
		acc_d = acc_q;
		dig_d = dig_q;
		dig_hi_d = dig_hi_q;
		buf_d = buf_q;
		send_cnt_d = send_cnt_q;
		send_run_d = send_run_q;
		run_d = run_q;
		swoff_n_d = swoff_n_q;
		lvl_d = lvl_q;
		vec_d = vec_q;
		psw_val_d = psw_val_q;
		cmd_code_d = cmd_code_q;
		operand_d = operand_q;
		tx_byte_d = tx_byte_q;
		tx_go_d = 1'b0;
		psw_ld_d = 1'b0;
		loader_d = 1'b0;
		auto_d = 1'b0;
		branch_d = 1'b0;
		clear_n_d = 1'b1;
		int_d = 1'b0;
		cmd_v_d = 1'b0;
		hh_rst_d = 1'b0;
		src_set = {pg_rise, pon_fall, run_fall, rx_start_q};
		src_d = (src_q & ~i_fw_source_clr) | src_set; // set wins over clear
		fw_int_d = |src_set;
		unique case (ctl_q)
			CT_CMD: begin
				if (rx_valid_q && known && allowed) begin
					cmd_d = rx_byte_q;
					acc_d = 20'h00000;
					cmd_code_d = rx_byte_q;
					operand_d = 20'h00000;
					ctl_d = CT_SEND;
					send_run_d = 1'b1;
					case (rx_byte_q)
						`CPI_CMD_LOAD_REGISTER: begin
							dig_d = `CPI_DIGITS_REG_LOAD;
							dig_hi_d = `CPI_DIG_REG_HI;
							ctl_d = CT_COLLECT;
						end
						`CPI_CMD_READ_REGISTER: begin
							dig_d = `CPI_DIGITS_REG_ADDR;
							dig_hi_d = `CPI_DIG_REG_HI;
							ctl_d = CT_COLLECT;
						end
						`CPI_CMD_LOAD_MEMORY, `CPI_CMD_LOAD_MEMORY_SECOND: begin
							dig_d = `CPI_DIGITS_WORD;
							dig_hi_d = `CPI_DIG_REG_HI;
							ctl_d = CT_COLLECT;
						end
						`CPI_CMD_LOAD_ADDRESS: begin
							dig_d = `CPI_DIGITS_MEM_ADDR;
							dig_hi_d = `CPI_DIG_MEM_HI;
							ctl_d = CT_COLLECT;
						end
						`CPI_CMD_READ_MEMORY, `CPI_CMD_READ_MEMORY_SECOND, `CPI_CMD_READ_ADDRESS: begin
							cmd_v_d = 1'b1;
							ctl_d = CT_WAIT;
						end
						`CPI_CMD_READ_STATUS: begin
							buf_d = i_psw;
							send_cnt_d = `CPI_DIGITS_WORD;
							send_run_d = 1'b0;
						end
						default: begin
							cmd_v_d = 1'b1;
						end
					endcase
					if (rx_byte_q == `CPI_CMD_INTERRUPT) begin
						int_d = 1'b1;
						lvl_d = `CPI_LEVEL_PANEL;
					end
					if (rx_byte_q == `CPI_CMD_LOAD_LOADER) begin
						loader_d = 1'b1;
						psw_ld_d = 1'b1;
						psw_val_d = 16'h0000;
						psw_val_d[`CPI_PSW_PL_LSB +: `CPI_PSW_PL_W] = `CPI_LEVEL_LOADER;
					end
					if (rx_byte_q == `CPI_CMD_MASTER_CLEAR) begin
						run_d = 1'b0;
					end
					if (rx_byte_q == `CPI_CMD_RUN) begin
						run_d = 1'b1;
					end
				end
			end
			CT_COLLECT: begin
				if (rx_valid_q) begin
					if (rx_byte_q[7:4] != dig_hi_q) begin
						ctl_d = CT_CMD; // bad digit drops the whole command
					end else begin
						acc_d = {acc_q[15:0], rx_byte_q[3:0]};
						dig_d = dig_q - 1'b1;
						if (dig_q == 3'h1) begin
							cmd_v_d = 1'b1;
							cmd_code_d = cmd_q;
							operand_d = acc_d;
							ctl_d = (cmd_q == `CPI_CMD_READ_REGISTER) ? CT_WAIT : CT_SEND;
						end
					end
				end
			end
			CT_WAIT: begin
				if (i_reply_valid) begin
					buf_d = i_reply_data;
					send_cnt_d = `CPI_DIGITS_WORD;
					send_run_d = 1'b0;
					ctl_d = CT_SEND;
				end
			end
			CT_SEND: begin
				if (tx_q == TX_IDLE && !tx_go_q) begin
					if (send_cnt_q != 3'h0) begin
						tx_go_d = 1'b1;
						tx_byte_d = {`CPI_DIG_REG_HI, buf_q[15:12]};
						buf_d = {buf_q[11:0], 4'h0};
						send_cnt_d = send_cnt_q - 1'b1;
					end else if (send_run_q) begin
						tx_go_d = 1'b1;
						tx_byte_d = run_q ? `CPI_REPLY_RUNNING : `CPI_REPLY_NOT_RUNNING;
						send_run_d = 1'b0;
					end else begin
						ctl_d = CT_CMD;
					end
				end
			end
		endcase
		// operator panel run button starts the loader
		if (run_fall) begin
			loader_d = 1'b1;
			psw_ld_d = 1'b1;
			psw_val_d = 16'h0000;
			psw_val_d[`CPI_PSW_PL_LSB +: `CPI_PSW_PL_W] = `CPI_LEVEL_LOADER;
			run_d = 1'b1;
		end
		// planned off: software decides while running, hardware when idle
		if (pon_fall) begin
			if (run_q) begin
				int_d = 1'b1;
				lvl_d = `CPI_LEVEL_PLANNED_OFF;
			end else begin
				swoff_n_d = 1'b0;
			end
		end
		// power-up start routine has the last word
		if (pg_rise) begin
			int_d = 1'b1;
			lvl_d = `CPI_LEVEL_POWER;
			hh_rst_d = 1'b1;
			if (restart_s) begin
				clear_n_d = 1'b0;
				psw_ld_d = 1'b1;
				psw_val_d = 16'h0000;
				psw_val_d[`CPI_PSW_PL_LSB +: `CPI_PSW_PL_W] = `CPI_LEVEL_RESTART;
				branch_d = 1'b1;
				run_d = 1'b1;
			end else if (!lock_s) begin
				run_d = 1'b0;
			end else if (retained_s) begin
				auto_d = 1'b1;
				run_d = 1'b1;
			end else begin
				loader_d = 1'b1;
				psw_ld_d = 1'b1;
				psw_val_d = 16'h0000;
				psw_val_d[`CPI_PSW_PL_LSB +: `CPI_PSW_PL_W] = `CPI_LEVEL_LOADER;
				run_d = 1'b1;
			end
		end
		vec_d = 16'({lvl_d, 1'b0}); // vector table holds one word per level
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctl_q <= CT_CMD;
			cmd_q <= 8'h00;
			acc_q <= 20'h00000;
			dig_q <= 3'h0;
			dig_hi_q <= 4'h0;
			buf_q <= 16'h0000;
			send_cnt_q <= 3'h0;
			send_run_q <= 1'b0;
			run_q <= 1'b0;
			swoff_n_q <= 1'b1;
			lvl_q <= 6'h00;
			vec_q <= 16'h0000;
			psw_val_q <= 16'h0000;
			cmd_code_q <= 8'h00;
			operand_q <= 20'h00000;
			tx_byte_q <= 8'h00;
			tx_go_q <= 1'b0;
			psw_ld_q <= 1'b0;
			loader_q <= 1'b0;
			auto_q <= 1'b0;
			branch_q <= 1'b0;
			clear_n_q <= 1'b1;
			int_q <= 1'b0;
			cmd_v_q <= 1'b0;
			hh_rst_q <= 1'b0;
			src_q <= 4'h0;
			fw_int_q <= 1'b0;
			pg_prev_q <= 1'b0;
			run_prev_q <= 1'b1;
			pon_prev_q <= 1'b1;
		end else if (i_ce) begin
			ctl_q <= ctl_d;
			cmd_q <= cmd_d;
			acc_q <= acc_d;
			dig_q <= dig_d;
			dig_hi_q <= dig_hi_d;
			buf_q <= buf_d;
			send_cnt_q <= send_cnt_d;
			send_run_q <= send_run_d;
			run_q <= run_d;
			swoff_n_q <= swoff_n_d;
			lvl_q <= lvl_d;
			vec_q <= vec_d;
			psw_val_q <= psw_val_d;
			cmd_code_q <= cmd_code_d;
			operand_q <= operand_d;
			tx_byte_q <= tx_byte_d;
			tx_go_q <= tx_go_d;
			psw_ld_q <= psw_ld_d;
			loader_q <= loader_d;
			auto_q <= auto_d;
			branch_q <= branch_d;
			clear_n_q <= clear_n_d;
			int_q <= int_d;
			cmd_v_q <= cmd_v_d;
			hh_rst_q <= hh_rst_d;
			src_q <= src_d;
			fw_int_q <= fw_int_d;
			pg_prev_q <= pg_s;
			run_prev_q <= run_n_s;
			pon_prev_q <= pon_n_s;
		end
	end

	// ----------------------------------------------------------------
	// operator panel register and clock tick gate
	// ----------------------------------------------------------------
	logic [7:0] op_out_q, op_out_d, rdata_q, rdata_d;
	logic rtc_q, rtc_d;

	always_comb begin
		op_out_d = op_out_q;
		if (i_ext_wr && i_ext_addr == `CPI_EXT_PANEL_ADDR) begin
			op_out_d = i_ext_wdata;
		end
		rdata_d = (i_ext_rd && i_ext_addr == `CPI_EXT_PANEL_ADDR) ? {2'b00, op_s} : 8'h00;
		rtc_d = tick_s && tick_en_s;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			op_out_q <= 8'h00;
			rdata_q <= 8'h00;
			rtc_q <= 1'b0;
		end else if (i_ce) begin
			op_out_q <= op_out_d;
			rdata_q <= rdata_d;
			rtc_q <= rtc_d;
		end
	end

	assign o_serial_host_to_panel = tx_out_q;
	assign o_handheld_panel_reset = hh_rst_q;
	assign o_rtc_tick = rtc_q;
	assign o_system_clear_n = clear_n_q;
	assign o_software_off_n = swoff_n_q;
	assign o_operator_panel_data = op_out_q;
	assign o_ext_rdata = rdata_q;
	assign o_fw_interrupt = fw_int_q;
	assign o_fw_source = src_q;
	assign o_int_req = int_q;
	assign o_int_level = lvl_q;
	assign o_int_vector = vec_q;
	assign o_cmd_valid = cmd_v_q;
	assign o_cmd_code = cmd_code_q;
	assign o_cmd_operand = operand_q;
	assign o_psw_load = psw_ld_q;
	assign o_psw_value = psw_val_q;
	assign o_loader_load = loader_q;
	assign o_auto_restart = auto_q;
	assign o_branch = branch_q;
	assign o_branch_addr = `CPI_RESTART_ADDR;
	assign o_run_state = run_q;
endmodule

// File: cpi_panel_if_sva.sv
// port assertions for the control panel interface
`timescale 1ns/1ns
module cpi_panel_if_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_rtc_tick_enable,
	input wire logic o_rtc_tick,
	input wire logic o_system_clear_n,
	input wire logic o_software_off_n,
	input wire logic [7:0] o_operator_panel_data,
	input wire logic i_ext_wr,
	input wire logic [7:0] i_ext_addr,
	input wire logic [7:0] i_ext_wdata,
	input wire logic o_fw_interrupt,
	input wire logic [3:0] o_fw_source,
	input wire logic o_int_req,
	input wire logic [5:0] o_int_level,
	input wire logic [15:0] o_int_vector,
	input wire logic o_psw_load,
	input wire logic [15:0] o_psw_value,
	input wire logic o_loader_load,
	input wire logic o_branch,
	input wire logic o_handheld_panel_reset
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_rtc; o_rtc_tick |-> $past(i_rtc_tick_enable, 3); endproperty
	a_rtc: assert property (p_rtc) else $error("tick passed while disabled");
	property p_vec; o_int_req |-> o_int_vector == {9'h000, o_int_level, 1'b0}; endproperty
	a_vec: assert property (p_vec) else $error("vector not twice level");
	property p_ldr; o_loader_load |-> ##[0:1] (o_psw_load && o_psw_value == 16'h003F); endproperty
	a_ldr: assert property (p_ldr) else $error("loader status word wrong");
	property p_clr; $fell(o_system_clear_n) |-> ##[0:2] (o_branch && o_psw_value == 16'h0000); endproperty
	a_clr: assert property (p_clr) else $error("restart branch missing");
	property p_off; !o_software_off_n |=> !o_software_off_n; endproperty
	a_off: assert property (p_off) else $error("software off released");
	property p_pwr; o_handheld_panel_reset |-> ##[0:1] (o_int_req && o_int_level == 6'h00 && o_fw_source[3]); endproperty
	a_pwr: assert property (p_pwr) else $error("power-up level wrong");
	property p_fw; o_fw_interrupt |-> ##[0:1] (o_fw_source != 4'h0); endproperty
	a_fw: assert property (p_fw) else $error("no interrupt source");
	property p_ext; i_ext_wr && i_ext_addr == 8'hF6 |=> o_operator_panel_data == $past(i_ext_wdata); endproperty
	a_ext: assert property (p_ext) else $error("panel write lost");
endmodule
bind cpi_panel_if cpi_panel_if_sva u_sva (.*);

// File: cpi_hhp_model.sv
// serial hand-held panel model: frames bytes out, collects reply bytes
`timescale 1ns/1ns
module cpi_hhp_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_serial_host_to_panel,
	output logic o_serial_panel_to_host
);
	logic [7:0] rx_q[$];
	logic [7:0] rb;
	initial o_serial_panel_to_host = 1'b1;
	// low start, lsb first, high stop, idle high; call just after an edge
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_serial_panel_to_host = f[i];
			repeat (BIT_CYCLES) @(posedge i_clk_sys);
			#1;
		end
	endtask
	// sample replies mid bit; a frame with a low stop bit is not kept
	always begin
		@(negedge i_serial_host_to_panel);
		repeat (BIT_CYCLES / 2) @(posedge i_clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge i_clk_sys);
			rb[i] = i_serial_host_to_panel;
		end
		repeat (BIT_CYCLES) @(posedge i_clk_sys);
		if (i_serial_host_to_panel) rx_q.push_back(rb);
	end
endmodule

// File: cpi_panel_if_tb_top.sv
// self-checking bench for the control panel interface
`timescale 1ns/1ns
module cpi_panel_if_tb_top;
	localparam int BC = 16;
	logic clk = 0, rst = 1, lock = 0, tk = 0, tke = 0, run_n = 1, rsr = 1, off_n = 1, pg = 0, ewr = 0, erd = 0, rv = 0;
	logic [7:0] ea = '0, ewd = '0, erdata, opd, code_o, m_code;
	logic [5:0] pd = '0, lvl_o, m_lvl;
	logic [3:0] fclr = '0, src;
	logic [15:0] program_status_word = '0, rd = '0, vec_o, psv_o, m_vec, m_psw;
	logic [19:0] op_o, m_op;
	logic p2h, h2p, clr_n, soff_n, ireq, cv, psl, run, er, s_clr, s_int, s_cv, ar, s_ar, ret = 0;
	logic [7:0] cl[18] = '{8'h40, 8'h49, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h4B, 8'h44, 8'h46, 8'h41, 8'h42, 8'h45,
		8'h55, 8'h48, 8'h43, 8'h47, 8'h57, 8'h4A};
	integer seed = 98, errors = 0, n_compared = 0;
	cpi_panel_if #(.BIT_CYCLES(BC)) uut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_serial_panel_to_host(p2h),
		.o_serial_host_to_panel(h2p), .o_handheld_panel_reset(), .i_lock(lock), .i_rtc_tick(tk),
		.i_rtc_tick_enable(tke), .o_rtc_tick(), .i_run_request_n(run_n), .i_restart_request(rsr),
		.i_planned_off_request_n(off_n), .i_power_good_monitor(pg), .i_memory_retained(ret),
		.o_system_clear_n(clr_n), .o_software_off_n(soff_n), .i_operator_panel_data(pd),
		.o_operator_panel_data(opd), .i_ext_rd(erd), .i_ext_wr(ewr), .i_ext_addr(ea), .i_ext_wdata(ewd),
		.o_ext_rdata(erdata), .o_fw_interrupt(), .o_fw_source(src), .i_fw_source_clr(fclr), .o_int_req(ireq),
		.o_int_level(lvl_o), .o_int_vector(vec_o), .o_cmd_valid(cv), .o_cmd_code(code_o), .o_cmd_operand(op_o),
		.i_psw(program_status_word), .i_reply_valid(rv), .i_reply_data(rd), .o_psw_load(psl), .o_psw_value(psv_o),
		.o_loader_load(), .o_auto_restart(ar), .o_branch(), .o_branch_addr(), .o_run_state(run));
	cpi_hhp_model #(.BIT_CYCLES(BC)) hhp (.i_clk_sys(clk), .i_serial_host_to_panel(h2p), .o_serial_panel_to_host(p2h));
	always #10 clk = ~clk;
	// just after each edge: random tick pins, reply strobe, pulse capture
	always begin
		@(posedge clk);
		#1;
		{tk, tke} = 2'($random(seed));
		rv = cv && (code_o inside {8'h42, 8'h47, 8'h57, 8'h4A});
		if (!clr_n) s_clr = 1;
		if (ireq) begin
			s_int = 1;
			m_lvl = lvl_o;
			m_vec = vec_o;
		end
		if (psl) m_psw = psv_o;
		if (ar) s_ar = 1;
		if (cv) begin
			s_cv = 1;
			m_code = code_o;
			m_op = op_o;
		end
	end
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic arm();
		hhp.rx_q.delete();
		s_clr = 0;
		s_int = 0;
		s_cv = 0;
		s_ar = 0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b);
		hhp.send_byte(b);
		tick(4);
	endtask
	// wait for n reply bytes, bounded
	task automatic get_reply(input int n);
		for (int k = 0; k < 60 * BC && hhp.rx_q.size() < n; k++) @(posedge clk);
		#1;
		chk("reply count", n, hhp.rx_q.size());
	endtask
	// one command with its digits; expects a run byte or four status digits
	task automatic run_cmd(input logic [7:0] c, input int nd, input logic [3:0] hi, input logic [15:0] rw);
		logic [19:0] op = '0;
		logic [3:0] d;
		arm();
		rd = rw;
		program_status_word = rw;
		send(c);
		for (int i = 0; i < nd; i++) begin
			d = 4'($random(seed));
			op = {op[15:0], d};
			send({hi, d});
		end
		if (c == 8'h40) er = 0;
		if (c == 8'h4B) er = 1;
		if (c inside {8'h42, 8'h43, 8'h47, 8'h57, 8'h4A}) begin
			get_reply(4);
			for (int i = 0; i < 4; i++) chk("digit", {4'h3, rw[15-4*i -: 4]}, hhp.rx_q[i]);
		end else begin
			get_reply(1);
			chk("run byte", {7'h20, er}, hhp.rx_q[0]);
		end
		// read status answers by itself without a strobe, so its code is read where it stands
		chk("code", c, c == 8'h43 ? code_o : m_code);
		if (nd > 0) chk("operand", op, m_op);
	endtask
	task automatic drop(input logic [7:0] b);
		arm();
		send(b);
		tick(12 * BC);
		chk("dropped", 0, {s_cv, 8'(hhp.rx_q.size())});
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, well above the some 13000 cycles the tests need
	initial begin
		repeat (80000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		tick(16);
		rst = 0;
		arm();
		pg = 1;
		tick(8);
		chk("restart", {1'b1, 6'h00, 16'h0000}, {s_clr, m_lvl, m_vec});
		chk("restart run", {2'b11, 16'h0000}, {src[3], run, m_psw});
		$display("test power done");
		er = 1;
		foreach (cl[i])
			run_cmd(cl[i], cl[i] inside {8'h41, 8'h48} ? 5 : cl[i] == 8'h42 ? 1 : cl[i][3:0] == 4'h5 ? 4 : 0,
				cl[i] == 8'h48 ? 4'hB : 4'h3, 16'($random(seed)));
		chk("loader psw", 16'h003F, m_psw);
		$display("test commands done");
		lock = 1;
		drop(8'h40);
		run_cmd(8'h46, 0, 4'h3, 16'h0000);
		chk("panel int", {1'b1, 6'h03, 16'h0006}, {s_int, m_lvl, m_vec});
		lock = 0;
		drop(8'h56);
		drop({4'h2, 4'($random(seed))});
		$display("test lock done");
		pd = 6'($random(seed));
		tick(2);
		{ewr, ea, ewd} = {1'b1, 8'hF6, 8'($random(seed))};
		tick(1);
		ewr = 0;
		erd = 1;
		tick(1);
		erd = 0;
		chk("panel out", ewd, opd);
		chk("panel in", {2'b00, pd}, erdata);
		fclr = 4'hF;
		tick(1);
		fclr = 4'h0;
		arm();
		run_n = 0;
		tick(8);
		chk("run request", {2'b11, 16'h003F}, {src[1], run, m_psw});
		run_n = 1;
		off_n = 0;
		tick(8);
		chk("off running", {6'h04, 16'h0008, 1'b1}, {m_lvl, m_vec, soff_n});
		off_n = 1;
		run_cmd(8'h40, 0, 4'h3, 16'h0000);
		arm();
		off_n = 0;
		tick(8);
		chk("off idle", 2'b00, {s_int, soff_n});
		$display("test panel done");
		// second power-up with lock held and memory kept must resume without reload
		rsr = 0;
		lock = 1;
		{ret, pg} = 2'b10;
		tick(4);
		arm();
		pg = 1;
		tick(8);
		chk("auto restart", 3'b110, {s_ar, run, s_clr});
		$display("test restart done");
		give_verdict();
	end
endmodule
